// *** core/ddp_host.sv ***
// Host controller driving the dual converter parallel load port.
module ddp_host
  import ddp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req_valid_i,
  input ddp_req_t req_i,
  output logic req_ready_o,
  input wire logic auto_update_i,
  input wire logic clear_i,
  output logic rd_valid_o,
  output logic [DATA_W-1:0] rd_data_o,
  input wire logic [DATA_W-1:0] code_bus_i,
  output ddp_pins_t pins_o
);
  typedef struct packed {
    ddp_state_t st;
    logic [CNT_W-1:0] cnt;
    logic is_read;
    logic do_load;
    ddp_pins_t pins;
    logic rd_valid;
    logic [DATA_W-1:0] rd_data;
  } ddp_host_st_t;
  ddp_host_st_t s_q, s_d;
  logic [DATA_W-1:0] bus_sync;

  function automatic logic [CNT_W-1:0] cyc(input int n);
    return CNT_W'(n);
  endfunction : cyc

  ddp_sync #(.W(DATA_W)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(code_bus_i),
    .q_o(bus_sync)
  );

  assign req_ready_o = (s_q.st == ST_IDLE) && !clear_i;

  always_comb begin
    s_d = s_q;
    s_d.rd_valid = 1'b0;
    s_d.pins.clear_n = !clear_i;
    if (s_q.cnt != CNT_ZERO) begin
      s_d.cnt = s_q.cnt - CNT_ONE;
    end
    case (s_q.st)
      ST_IDLE: begin
        s_d.pins.cs_n = 1'b1;
        s_d.pins.load_strobe_n = !auto_update_i;
        if (req_valid_i && !clear_i) begin
          if (req_i.write || req_i.read) begin
            s_d.is_read = req_i.read && !req_i.write;
            s_d.do_load = req_i.load;
            s_d.pins.chan_sel = req_i.chan_b;
            s_d.pins.rw = s_d.is_read;
            s_d.pins.code_bus_o = req_i.code;
            s_d.pins.code_bus_oe = !s_d.is_read;
            s_d.cnt = cyc(s_d.is_read ? RW_CS_CYC : ADDR_SU_CYC);
            s_d.st = ST_SETUP;
          end else if (req_i.load && !auto_update_i) begin
            s_d.pins.load_strobe_n = 1'b0;
            s_d.cnt = cyc(CS_LOW_CYC);
            s_d.st = ST_LOAD;
          end
        end
      end
      ST_SETUP: begin
        if (s_q.cnt <= CNT_ONE) begin
          s_d.pins.cs_n = 1'b0;
          // A read keeps chip select low until the bus has crossed the
          // synchroniser, so the captured code is never the stale one.
          s_d.cnt = cyc(s_q.is_read ? ACCESS_CYC + SYNC_LAT_CYC : CS_LOW_CYC);
          s_d.st = ST_STROBE;
        end
      end
      ST_STROBE: begin
        if (s_q.cnt <= CNT_ONE) begin
          if (s_q.is_read) begin
            s_d.rd_valid = 1'b1;
            s_d.rd_data = bus_sync;
          end
          s_d.pins.cs_n = 1'b1;
          s_d.cnt = cyc(RELINQ_CYC);
          s_d.st = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (s_q.cnt <= CNT_ONE) begin
          s_d.pins.code_bus_oe = 1'b0;
          s_d.pins.rw = 1'b1;
          if (s_q.do_load && !auto_update_i && !s_q.is_read) begin
            s_d.pins.load_strobe_n = 1'b0;
            s_d.cnt = cyc(CS_LOW_CYC);
            s_d.st = ST_LOAD;
          end else begin
            s_d.cnt = cyc(CS_HIGH_CYC);
            s_d.st = ST_GAP;
          end
        end
      end
      ST_LOAD: begin
        if (s_q.cnt <= CNT_ONE) begin
          s_d.pins.load_strobe_n = 1'b1;
          s_d.cnt = cyc(CS_HIGH_CYC);
          s_d.st = ST_GAP;
        end
      end
      ST_GAP: begin
        // The gap keeps chip select high long enough between accesses.
        if (s_q.cnt <= CNT_ONE) begin
          s_d.st = ST_IDLE;
        end
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.st <= ST_IDLE;
      s_q.pins.cs_n <= 1'b1;
      s_q.pins.rw <= 1'b1;
      s_q.pins.load_strobe_n <= 1'b1;
      // Clear is held during reset so the device starts from zero.
      s_q.pins.clear_n <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pins_o = s_q.pins;
  assign rd_valid_o = s_q.rd_valid;
  assign rd_data_o = s_q.rd_data;
endmodule : ddp_host

// *** core/ddp_pkg.sv ***
// Package of types and timing constants for the converter port host.
package ddp_pkg;
  localparam int DATA_W = 12;
  localparam int CLK_HZ = 20_000_000;
  localparam int CLK_NS = 1_000_000_000 / CLK_HZ;
  // Least times in ns, rounded up to whole cycles, never below one.
  localparam int T_CS_LOW_NS = 10;
  localparam int T_ADDR_SU_NS = 10;
  localparam int T_CS_HIGH_NS = 7;
  localparam int T_RW_CS_NS = 5;
  localparam int T_ACCESS_NS = 35;
  localparam int T_RELINQ_NS = 10;

  function automatic int ns2cyc(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction : ns2cyc

  localparam int CS_LOW_CYC = ns2cyc(T_CS_LOW_NS);
  localparam int ADDR_SU_CYC = ns2cyc(T_ADDR_SU_NS);
  localparam int CS_HIGH_CYC = ns2cyc(T_CS_HIGH_NS);
  localparam int RW_CS_CYC = ns2cyc(T_RW_CS_NS);
  localparam int ACCESS_CYC = ns2cyc(T_ACCESS_NS);
  localparam int RELINQ_CYC = ns2cyc(T_RELINQ_NS);
  // Three synchroniser stages plus the agreeing output stage.
  localparam int SYNC_LAT_CYC = 4;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_STROBE = 3'b010,
    ST_HOLD = 3'b011,
    ST_GAP = 3'b100,
    ST_LOAD = 3'b101
  } ddp_state_t;

  // Request from the user side.
  typedef struct packed {
    logic write;
    logic read;
    logic load;
    logic chan_b;
    logic [DATA_W-1:0] code;
  } ddp_req_t;

  // Pin group toward the converter.
  typedef struct packed {
    logic cs_n;
    logic rw;
    logic chan_sel;
    logic load_strobe_n;
    logic clear_n;
    logic [DATA_W-1:0] code_bus_o;
    logic code_bus_oe;
  } ddp_pins_t;
endpackage : ddp_pkg

// *** core/ddp_sync.sv ***
// Three-stage synchroniser for the readback bus, change on stages two/three.
module ddp_sync
  import ddp_pkg::*;
#(
  parameter int W = DATA_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } ddp_sync_st_t;
  ddp_sync_st_t st_q, st_d;

  always_comb begin
    st_d = st_q;
    st_d.s1 = d_i;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    // A new value counts only once two later stages agree.
    if (st_q.s2 == st_q.s3) begin
      st_d.q = st_q.s3;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign q_o = st_q.q;
endmodule : ddp_sync

// *** sim/ddp_host_assertions.sv ***
// Checker of the pin sequence driven by the converter port host.
module ddp_host_assertions
  import ddp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input ddp_pins_t pins_o,
  input wire logic rd_valid_o,
  input wire logic req_ready_o,
  input wire logic auto_update_i,
  input wire logic clear_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence sel_end;
    $rose(pins_o.cs_n) && pins_o.rw;
  endsequence
  chk_write_rw_low: assert property (
    pins_o.code_bus_oe && !pins_o.cs_n |-> !pins_o.rw)
    else $error("rw high in write");
  chk_sel_held: assert property (
    !pins_o.cs_n |=> $stable(pins_o.chan_sel)) else $error("select moved");
  chk_code_held: assert property (
    !pins_o.cs_n && pins_o.code_bus_oe |=> $stable(pins_o.code_bus_o))
    else $error("code moved");
  chk_read_after_cs: assert property (
    rd_valid_o |-> sel_end) else $error("readback outside access");
  chk_auto_strobe_low: assert property (
    auto_update_i && req_ready_o |=> !pins_o.load_strobe_n)
    else $error("load strobe high in auto mode");
  chk_clear_follow: assert property (
    clear_i |=> !pins_o.clear_n) else $error("clear not driven");
  chk_read_bus_free: assert property (
    pins_o.rw && !pins_o.cs_n |-> !pins_o.code_bus_oe)
    else $error("host drives bus in readback");
endmodule : ddp_host_assertions
bind ddp_host ddp_host_assertions chk (.clk_i(clk_i), .rst_i(rst_i),
  .pins_o(pins_o), .rd_valid_o(rd_valid_o), .req_ready_o(req_ready_o),
  .auto_update_i(auto_update_i), .clear_i(clear_i));

// *** sim/ddp_dev_model.sv ***
// Behavioural model of the dual converter parallel port.
module ddp_dev_model
  import ddp_pkg::*;
(
  input ddp_pins_t pins_i,
  input wire logic [DATA_W-1:0] bus_i,
  output logic [DATA_W-1:0] dout_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [DATA_W-1:0] lat [2];
  logic [DATA_W-1:0] dac [2];
  logic den;
  // Released bus shows the inverse so a stale value never passes.
  assign den = !pins_i.cs_n && pins_i.rw;
  assign dout_o = den ? dac[pins_i.chan_sel] : ~dac[pins_i.chan_sel];
  always @(posedge pins_i.cs_n) begin
    if (pins_i.clear_n && !pins_i.rw) begin
      lat[pins_i.chan_sel] = bus_i;
      if (!pins_i.load_strobe_n) dac[pins_i.chan_sel] = bus_i;
    end
  end
  always @(negedge pins_i.load_strobe_n) dac = lat;
  always @(negedge pins_i.clear_n) begin
    lat = '{default: '0};
    dac = '{default: '0};
  end
endmodule : ddp_dev_model

// *** sim/ddp_host_bench.sv ***
// Self-checking bench of the converter port host.
module ddp_host_bench;
  import ddp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i, rst_i, req_valid_i, auto_update_i, clear_i, req_ready_o;
  logic rd_valid_o;
  logic [DATA_W-1:0] rd_data_o, code_bus_i, dout, rd_seen;
  ddp_req_t req_i;
  ddp_pins_t pins_o;
  int error_cnt, cmp_count;
  ddp_host dut (.clk_i(clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i),
    .req_i(req_i), .req_ready_o(req_ready_o), .auto_update_i(auto_update_i),
    .clear_i(clear_i), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
    .code_bus_i(code_bus_i), .pins_o(pins_o));
  ddp_dev_model m (.pins_i(pins_o), .bus_i(code_bus_i), .dout_o(dout));
  assign code_bus_i = pins_o.code_bus_oe ? pins_o.code_bus_o : dout;
  always @(posedge clk_i) if (rd_valid_o === 1'b1) rd_seen <= rd_data_o;
  initial begin
    clk_i = 0;
    forever #25 clk_i = ~clk_i;
  end
  task automatic chk(string n, logic [11:0] e, logic [11:0] s);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic idle();
    int n;
    n = 0;
    while (req_ready_o !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      #1 n++;
    end
    if (req_ready_o !== 1'b1) begin
      error_cnt++;
      $display("FAIL ready expected 1 seen %b", req_ready_o);
    end
  endtask : idle
  task automatic req(logic w, r, l, b, logic [11:0] c);
    idle();
    req_valid_i = 1;
    req_i = '{w, r, l, b, c};
    @(posedge clk_i);
    #1 req_valid_i = 0;
    @(posedge clk_i);
    #1 idle();
  endtask : req
  task automatic t_write();
    req(1, 0, 1, 0, 12'h5a3);
    req(1, 0, 0, 1, 12'h800);
    chk("dac a", 12'h5a3, m.dac[0]);
    chk("dac b", 12'h000, m.dac[1]);
    req(0, 0, 1, 0, 12'h000);
    chk("dac b load", 12'h800, m.dac[1]);
    $display("write test done");
  endtask : t_write
  task automatic t_read();
    req(0, 1, 0, 0, 12'h000);
    chk("read a", 12'h5a3, rd_seen);
    req(0, 1, 0, 1, 12'h000);
    chk("read b", 12'h800, rd_seen);
    $display("read test done");
  endtask : t_read
  task automatic t_auto();
    auto_update_i = 1;
    req(1, 0, 0, 1, 12'h00f);
    chk("auto b", 12'h00f, m.dac[1]);
    auto_update_i = 0;
    clear_i = 1;
    repeat (3) @(posedge clk_i);
    #1 clear_i = 0;
    chk("clear", 12'h000, m.dac[1]);
    req(0, 1, 0, 0, 12'h000);
    chk("read cleared", 12'h000, rd_seen);
    $display("auto and clear test done");
  endtask : t_auto
  task automatic test_done();
    $display("checks %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  initial begin
    #200000 error_cnt++;
    test_done();
  end
  initial begin
    rst_i = 1;
    req_valid_i = 0;
    req_i = '0;
    auto_update_i = 0;
    clear_i = 0;
    repeat (20) @(posedge clk_i);
    #1 rst_i = 0;
    chk("power up", 12'h000, m.dac[0]);
    t_write();
    t_read();
    t_auto();
    test_done();
  end
endmodule : ddp_host_bench
